// *** hdl/exs_front.sv ***
// I2C slave front end of a 16-bit I/O expander: filtering, addressing, command byte.
// Assumes bus lines synchronous to clk_in; strap states sensed externally.
// How it works
// RL1 - Master sends address and direction after START before any access.
// RL2 - Last bit of first byte: one reads, zero writes.
// RL3 - Three strap pins pick one of 64 slave addresses.
// RL4 - After STOP the device is in standby until addressed again.
// RL5 - Reset clears bus logic and drives all I/O levels high.
// RL6 - Pulses under 50 ns on SCL and SDA are filtered out.
// RL7 - Four-state straps map to fixed 7-bit address; all ground gives 20h.
// RL8 - In a write, the byte after address is the command byte.
// RL9 - Commands 0..7 select input, output, polarity, config for ports 0/1.
// RL10 - Only a matching address is acknowledged; else ignore until START.
`timescale 1ns/1ns
module exs_front (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Bus lines
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  // Strap states
  input  wire logic [1:0]  addr_strap_pin_0_in,
  input  wire logic [1:0]  addr_strap_pin_1_in,
  input  wire logic [1:0]  addr_strap_pin_2_in,
  // Register side
  output logic [2:0]       reg_sel_out,
  output logic             reg_wr_out,
  output logic [7:0]       reg_wdata_out,
  input  wire logic [7:0]  reg_rdata_in,
  output logic             standby_out,
  output logic [15:0]      io_level_out
);

  typedef struct packed {
    logic [7:0]  scl_cnt;
    logic [7:0]  sda_cnt;
    logic        scl_f;
    logic        sda_f;
    logic        scl_d;
    logic        sda_d;
    exs_pkg::exs_state_t st;
    logic [3:0]  bit_cnt;
    logic [7:0]  shreg;
    logic [2:0]  sel;
    logic        wr;
    logic [7:0]  wdata;
    logic        drive;
    logic        standby;
    logic [15:0] io;
  } exs_front_t;

  exs_front_t state_reg;
  exs_front_t state_next;
  logic [6:0] own_addr;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;

  ////////////////////////////////////////////////////////////////////////////
  // Strap decode, table in 7-bit form
  always_comb begin
    logic [1:0] a0;
    logic [1:0] a1;
    logic [1:0] a2;
    a0 = addr_strap_pin_0_in;
    a1 = addr_strap_pin_1_in;
    a2 = addr_strap_pin_2_in;
    own_addr = 7'h00;
    own_addr[0] = (a0 == exs_pkg::STRAP_VDD) || (a0 == exs_pkg::STRAP_SDA); // RL3
    own_addr[3] = (a0 == exs_pkg::STRAP_SCL) || (a0 == exs_pkg::STRAP_SDA); // RL7
    own_addr[1] = (a1 == exs_pkg::STRAP_VDD) || (a1 == exs_pkg::STRAP_SDA); // RL7
    own_addr[2] = (a2 == exs_pkg::STRAP_VDD) || (a2 == exs_pkg::STRAP_SDA); // RL7
    // Upper bits: GND/VDD on AD1 with AD2 low-ish gives 010, SCL/SDA on AD1 gives 001
    if (a2 == exs_pkg::STRAP_GND || a2 == exs_pkg::STRAP_VDD) begin
      own_addr[6:4] = (a1[1]) ? 3'h1 : 3'h2; // RL7
    end else if (a1[1]) begin
      own_addr[6:4] = 3'h5;
    end else begin
      own_addr[6:4] = (a0[1]) ? 3'h7 : 3'h6;
      own_addr[3] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge and condition detection on filtered lines
  assign scl_rise = state_reg.scl_f & ~state_reg.scl_d;
  assign scl_fall = ~state_reg.scl_f & state_reg.scl_d;
  assign start_c  = state_reg.scl_f & state_reg.sda_d & ~state_reg.sda_f;
  assign stop_c   = state_reg.scl_f & ~state_reg.sda_d & state_reg.sda_f;

  always_comb begin
    state_next = state_reg;
    state_next.wr = 1'b0;
    state_next.scl_d = state_reg.scl_f;
    state_next.sda_d = state_reg.sda_f;
    // A level must persist SPIKE_CYC + 1 cycles before it is accepted
    if (scl_in == state_reg.scl_f) begin
      state_next.scl_cnt = 8'h00;
    end else if (state_reg.scl_cnt >= 8'(exs_pkg::SPIKE_CYC)) begin
      state_next.scl_f = scl_in; // RL6
      state_next.scl_cnt = 8'h00;
    end else begin
      state_next.scl_cnt = state_reg.scl_cnt + 8'h01;
    end
    if (sda_in == state_reg.sda_f) begin
      state_next.sda_cnt = 8'h00;
    end else if (state_reg.sda_cnt >= 8'(exs_pkg::SPIKE_CYC)) begin
      state_next.sda_f = sda_in; // RL6
      state_next.sda_cnt = 8'h00;
    end else begin
      state_next.sda_cnt = state_reg.sda_cnt + 8'h01;
    end

    if (start_c) begin
      state_next.st = exs_pkg::ST_ADDR; // RL1
      state_next.bit_cnt = 4'h0;
      state_next.drive = 1'b0;
    end else if (stop_c) begin
      state_next.st = exs_pkg::ST_IDLE;
      state_next.standby = 1'b1; // RL4
      state_next.drive = 1'b0;
    end else if (scl_rise) begin
      case (state_reg.st)
        exs_pkg::ST_ADDR, exs_pkg::ST_CMD, exs_pkg::ST_WDATA: begin
          state_next.shreg = {state_reg.shreg[6:0], state_reg.sda_f};
          state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
        end
        exs_pkg::ST_RDATA: begin
          state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
        end
        exs_pkg::ST_RACK: begin
          if (state_reg.sda_f) begin
            state_next.st = exs_pkg::ST_IDLE; // Master NACK ends read
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state_reg.st)
        exs_pkg::ST_ADDR: begin
          if (state_reg.bit_cnt == 4'h8) begin
            if (state_reg.shreg[7:1] == own_addr) begin // RL10
              state_next.st = exs_pkg::ST_AACK;
              state_next.drive = 1'b1;
              state_next.standby = 1'b0; // RL4
            end else begin
              state_next.st = exs_pkg::ST_IDLE; // RL10
            end
          end
        end
        exs_pkg::ST_AACK: begin
          state_next.bit_cnt = 4'h0;
          if (state_reg.shreg[0]) begin // RL2
            state_next.st = exs_pkg::ST_RDATA;
            state_next.shreg = reg_rdata_in;
            state_next.drive = ~reg_rdata_in[7];
          end else begin
            state_next.st = exs_pkg::ST_CMD; // RL8
            state_next.drive = 1'b0;
          end
        end
        exs_pkg::ST_CMD: begin
          if (state_reg.bit_cnt == 4'h8) begin
            state_next.sel = state_reg.shreg[2:0]; // RL9
            state_next.st = exs_pkg::ST_CACK;
            state_next.drive = 1'b1;
          end
        end
        exs_pkg::ST_WDATA: begin
          if (state_reg.bit_cnt == 4'h8) begin
            state_next.wdata = state_reg.shreg;
            state_next.wr = 1'b1;
            state_next.st = exs_pkg::ST_WACK;
            state_next.drive = 1'b1;
          end
        end
        exs_pkg::ST_CACK, exs_pkg::ST_WACK: begin
          state_next.st = exs_pkg::ST_WDATA;
          state_next.bit_cnt = 4'h0;
          state_next.drive = 1'b0;
          if (state_reg.st == exs_pkg::ST_WACK) begin
            state_next.sel = state_reg.sel ^ 3'h1; // Alternate within port pair
          end
        end
        exs_pkg::ST_RDATA: begin
          if (state_reg.bit_cnt == 4'h8) begin
            state_next.st = exs_pkg::ST_RACK;
            state_next.drive = 1'b0;
            state_next.sel = state_reg.sel ^ 3'h1;
          end else begin
            state_next.shreg = {state_reg.shreg[6:0], 1'b0};
            state_next.drive = ~state_reg.shreg[6];
          end
        end
        exs_pkg::ST_RACK: begin
          state_next.st = exs_pkg::ST_RDATA;
          state_next.bit_cnt = 4'h0;
          state_next.shreg = reg_rdata_in;
          state_next.drive = ~reg_rdata_in[7];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= '0; // RL5
      state_reg.scl_f <= 1'b1;
      state_reg.sda_f <= 1'b1;
      state_reg.scl_d <= 1'b1;
      state_reg.sda_d <= 1'b1;
      state_reg.st <= exs_pkg::ST_IDLE;
      state_reg.standby <= 1'b1;
      state_reg.io <= exs_pkg::IO_RESET; // RL5
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain: only ever pull low
  assign sda_out       = 1'b0;
  assign sda_oe_out    = state_reg.drive;
  assign reg_sel_out   = state_reg.sel;
  assign reg_wr_out    = state_reg.wr;
  assign reg_wdata_out = state_reg.wdata;
  assign standby_out   = state_reg.standby;
  assign io_level_out  = state_reg.io;

endmodule

// *** hdl/exs_pkg.sv ***
// Constants for the expander bus front end.
// Assumes a 50 MHz system clock that samples the bus lines.
package exs_pkg;
  // Clock and filter timing
  localparam int CLK_MHZ        = 50;
  localparam int SPIKE_NS       = 50;
  localparam int SPIKE_CYC      = (SPIKE_NS * CLK_MHZ + 999) / 1000;
  // Strap sensing states
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_VDD = 2'h1;
  localparam logic [1:0] STRAP_SCL = 2'h2;
  localparam logic [1:0] STRAP_SDA = 2'h3;
  // Command space
  localparam logic [7:0] CMD_LAST = 8'h07;
  // Reset value of the I/O level output
  localparam logic [15:0] IO_RESET = 16'hffff;
  typedef enum {ST_IDLE, ST_ADDR, ST_AACK, ST_CMD, ST_CACK, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK} exs_state_t;
endpackage

// *** sim/exs_master.sv ***
// Bus master model for the expander front end.
// Assumes SDA is a pulled-up open-drain wire built by the bench.
`timescale 1ns/1ns
module exs_master (
  // Clock and bus
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_rel_out
);
  bit glitch = 0;
  initial scl_out = 1;
  initial sda_rel_out = 1;
  task automatic wait_c(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // SDA moves two cycles after SCL falls so the filters never see a false start
  task automatic bit_x(input logic b, output logic s);
    wait_c(2);
    sda_rel_out = b;
    wait_c(10);
    scl_out = 1;
    wait_c(5);
    s = sda_in;
    if (glitch) begin
      scl_out = 0;
      wait_c(3);
      scl_out = 1;
    end
    wait_c(5);
    scl_out = 0;
  endtask
  task automatic start();
    sda_rel_out = 0;
    wait_c(10);
    scl_out = 0;
  endtask
  task automatic stop();
    wait_c(2);
    sda_rel_out = 0;
    wait_c(10);
    scl_out = 1;
    wait_c(10);
    sda_rel_out = 1;
    wait_c(10);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(ack_in, ack);
  endtask
endmodule

// *** sim/exs_monitor.sv ***
// Port checks for the expander bus front end.
// Bound to exs_front; every check runs on clk_in.
`timescale 1ns/1ns
module exs_monitor (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        rst_in,
  // Bus lines
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_out,
  // Register side
  input wire logic [2:0]  reg_sel_out,
  input wire logic        reg_wr_out,
  input wire logic        standby_out,
  input wire logic [15:0] io_level_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_rst;
    disable iff (1'b0) rst_in |=> standby_out && !sda_oe_out && !reg_wr_out && io_level_out == 16'hffff
      && reg_sel_out == 3'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  // The wired line must really go low whenever the front end claims to drive it
  property p_odrain; sda_oe_out |-> sda_out == 1'b0 && !sda_in; endproperty
  a_odrain: assert property (p_odrain) else $error("sda driven high");
  property p_oe_scl; $changed(sda_oe_out) |-> !scl_in; endproperty
  a_oe_scl: assert property (p_oe_scl) else $error("sda moved with scl high");
  property p_filt; $changed(sda_oe_out) |-> !$past(scl_in, 3); endproperty
  a_filt: assert property (p_filt) else $error("sda moved on short scl low");
  property p_stop; scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:8] standby_out; endproperty
  a_stop: assert property (p_stop) else $error("no standby after stop");
  property p_wr1; reg_wr_out |=> !reg_wr_out; endproperty
  a_wr1: assert property (p_wr1) else $error("write pulse too long");
  property p_wr_act; reg_wr_out |-> !standby_out && !scl_in; endproperty
  a_wr_act: assert property (p_wr_act) else $error("write outside transfer");
  property p_oe_act; sda_oe_out |-> !standby_out; endproperty
  a_oe_act: assert property (p_oe_act) else $error("sda driven in standby");
  c_ack: cover property (sda_oe_out);
  c_wr: cover property (reg_wr_out);
  c_stby: cover property ($rose(standby_out));
endmodule
bind exs_front exs_monitor exs_monitor_i (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .reg_sel_out(reg_sel_out), .reg_wr_out(reg_wr_out),
  .standby_out(standby_out), .io_level_out(io_level_out));

// *** sim/tb_top.sv ***
// Self-checking bench for the expander bus front end.
// Drives the bus through the master model; straps and read data set directly.
`timescale 1ns/1ns
module tb_top;
  localparam logic [1:0] G = exs_pkg::STRAP_GND, V = exs_pkg::STRAP_VDD;
  localparam logic [1:0] C = exs_pkg::STRAP_SCL, D = exs_pkg::STRAP_SDA;
  logic        clk_in = 0, rst_in = 1, scl, sda, sda_rel, sda_out, sda_oe_out, reg_wr_out, standby_out, ack;
  logic [1:0]  st0 = 0, st1 = 0, st2 = 0;
  logic [2:0]  reg_sel_out, wr_sel;
  logic [7:0]  reg_wdata_out, wr_data, q, rdata = 8'h00;
  logic [15:0] io_level_out;
  int          failures = 0, comparisons = 0, cycles = 0, wr_count = 0;
  always #10 clk_in = ~clk_in;
  assign sda = sda_rel & ~(sda_oe_out & ~sda_out);
  exs_front exs_front_i (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .addr_strap_pin_0_in(st0), .addr_strap_pin_1_in(st1), .addr_strap_pin_2_in(st2),
    .reg_sel_out(reg_sel_out), .reg_wr_out(reg_wr_out), .reg_wdata_out(reg_wdata_out), .reg_rdata_in(rdata),
    .standby_out(standby_out), .io_level_out(io_level_out));
  exs_master exs_master_i (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_rel_out(sda_rel));
  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (reg_wr_out === 1'b1) begin
      wr_sel <= reg_sel_out;
      wr_data <= reg_wdata_out;
      wr_count <= wr_count + 1;
    end
    if (cycles == 20000) begin
      failures = failures + 1;
      test_done();
    end
  end
  task automatic probe(input logic [1:0] p2, p1, p0, input logic [6:0] a, input logic exp);
    {st2, st1, st0} = {p2, p1, p0};
    exs_master_i.start();
    exs_master_i.xfer({a, 1'b0}, 1'b1, q, ack);
    chk(ack, exp);
    chk(standby_out, exp);
    exs_master_i.stop();
    chk(standby_out, 1'b1);
  endtask
  // Spiked SCL on the command byte must not shift the bit count
  task automatic t_write();
    {st2, st1, st0} = {G, G, G};
    exs_master_i.start();
    exs_master_i.xfer(8'h40, 1'b1, q, ack);
    exs_master_i.glitch = 1;
    exs_master_i.xfer(8'h07, 1'b1, q, ack);
    chk(ack, 1'b0);
    exs_master_i.glitch = 0;
    exs_master_i.xfer(8'h5c, 1'b1, q, ack);
    chk(ack, 1'b0);
    exs_master_i.stop();
    chk({wr_count[3:0], 1'b0, wr_sel, wr_data}, {4'h1, 1'b0, 3'h7, 8'h5c});
    chk(reg_sel_out, 3'h6);
  endtask
  // A foreign address must leave the device deaf until the next START
  task automatic t_ignore();
    {st2, st1, st0} = {G, G, G};
    exs_master_i.start();
    exs_master_i.xfer(8'h42, 1'b1, q, ack);
    exs_master_i.xfer(8'h40, 1'b1, q, ack);
    chk(ack, 1'b1);
    exs_master_i.stop();
  endtask
  task automatic t_reset();
    repeat (10) @(negedge clk_in);
    rst_in = 0;
    chk({standby_out, sda_oe_out, reg_wr_out, reg_sel_out}, 6'h20);
    chk(io_level_out, 16'hffff);
  endtask
  task automatic t_read();
    rdata = 8'ha5;
    exs_master_i.start();
    exs_master_i.xfer(8'h41, 1'b1, q, ack);
    chk(ack, 1'b0);
    exs_master_i.xfer(8'hff, 1'b1, q, ack);
    chk(q, 8'ha5);
    exs_master_i.stop();
  endtask
  initial begin
    t_reset();
    probe(G, G, G, 7'h20, 1'b0);
    probe(G, G, G, 7'h21, 1'b1);
    probe(V, V, V, 7'h27, 1'b0);
    probe(C, C, G, 7'h50, 1'b0);
    probe(D, D, D, 7'h5f, 1'b0);
    probe(G, C, G, 7'h10, 1'b0);
    t_ignore();
    t_write();
    t_read();
    test_done();
  end
endmodule
